// *** common/pmdma_regs.svh ***
// Register offsets, field positions, reset values and counts of the DMA block.
`ifndef PMDMA_REGS_SVH
`define PMDMA_REGS_SVH
// ****************************************
// Register offsets
// ****************************************
`define PMDMA_OFS_TUNING 8'h33
`define PMDMA_OFS_STATUS 8'h34
`define PMDMA_OFS_MASK 8'h35
`define PMDMA_OFS_RING_START 8'h36
`define PMDMA_OFS_RING_LAST 8'h37
`define PMDMA_OFS_HOST_IVL 8'h38
`define PMDMA_OFS_RX_PAGE 8'h39
`define PMDMA_OFS_TX_PAGE 8'h3A
// ****************************************
// Fields and reset values
// ****************************************
`define PMDMA_RBL_HI 7
`define PMDMA_RBL_LO 6
`define PMDMA_TBL_HI 5
`define PMDMA_TBL_LO 4
`define PMDMA_RTH_HI 3
`define PMDMA_RTH_LO 2
`define PMDMA_TTH_HI 1
`define PMDMA_TTH_LO 0
`define PMDMA_TUNING_RST 8'h05
`define PMDMA_TTH_SAF 2'h3
`define PMDMA_ST_RXFULL 0
`define PMDMA_ST_RXPAGE 1
`define PMDMA_ST_TXPAGE 2
`define PMDMA_ONE_PAGE 12'h001
`define PMDMA_BYTE_LAST 8'hFF
`define PMDMA_IVL_RST 8'h10
`endif

// *** common/pmdma_pkg.sv ***
// Types shared by the DMA arbiter and its channel counter.
package pmdma_pkg;
   // Bus owner of the packet memory.
   typedef enum logic [1:0] {
      PMDMA_IDLE = 2'b00,
      PMDMA_RX = 2'b01,
      PMDMA_TX = 2'b11,
      PMDMA_HOST = 2'b10
   } pmdma_owner_e;
endpackage

// *** common/pmdma_chan_if.sv ***
// Interface between the arbiter and one channel address counter.
`timescale 1ns/100ps
interface pmdma_chan_if;
   logic step;
   logic [11:0] start_page;
   logic [11:0] last_page;
   logic start_free;
   logic [19:0] addr;
   logic [11:0] page;
   logic page_done;
   logic wrap_fail;
   modport ctl(output step, output start_page, output last_page,
      output start_free, input addr, input page, input page_done,
      input wrap_fail);
   modport cnt(input step, input start_page, input last_page,
      input start_free, output addr, output page, output page_done,
      output wrap_fail);
endinterface

// *** hw/pmdma_chan.sv ***
// Page pointer plus byte counter forming one channel's memory address.
`timescale 1ns/100ps
`include "pmdma_regs.svh"
module pmdma_chan
   import pmdma_pkg::*;
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic ce,
   pmdma_chan_if.cnt c
);
   logic [11:0] page_q;
   logic [7:0] byte_q;
   logic end_of_page;

   // A page is used up when its last byte is moved.
   assign end_of_page = c.step && (byte_q == `PMDMA_BYTE_LAST);
   assign c.addr = {page_q, byte_q}; // R10 R16
   assign c.page = page_q;
   assign c.page_done = end_of_page;
   assign c.wrap_fail = end_of_page && (page_q == c.last_page)
      && !c.start_free; // R12

   // Byte counter restarts on every new page.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         byte_q <= 8'h00;
      end else if (ce && c.step) begin
         byte_q <= byte_q + 8'h01; // R18
      end
   end

   // Page advances by itself and wraps only onto a free start page.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         page_q <= 12'h000;
      end else if (ce && end_of_page) begin
         if (page_q != c.last_page) begin
            page_q <= page_q + `PMDMA_ONE_PAGE; // R11 R17
         end else if (c.start_free) begin
            page_q <= c.start_page; // R11 R17
         end
      end
   end

   // Assertions.
   a_byte_restart: assert property (@(posedge clk) disable iff (!nrst)
      ce && end_of_page |=> byte_q == 8'h00) // R18
      else $error("byte counter did not restart on new page");
endmodule

// *** hw/pmdma_arb.sv ***
// Packet memory arbiter with receive and transmit local DMA channels.
// ****************************************
// How it works
// R1 - Receive threshold bits 3:2 set critical level
// R2 - Transmit critical below threshold, never in store-forward
// R3 - Host critical once interval timer expires
// R4 - All critical: host, rx, tx; else round-robin
// R5 - Critical receive beats transmit always
// R6 - Non-critical receive: transmit equal or higher
// R7 - Receive burst length from bits 7:6
// R8 - Normally receive above transmit above host; the code alternates receive and transmit when both ask, host last
// R9 - Receive burst write holds bus to end
// R10 - Receive address is page and byte count
// R11 - Receive page advances, wraps to free start
// R12 - Occupied start page on wrap flags full
// R13 - Transmit threshold bits 1:0, default half
// R14 - Transmit burst length from bits 5:4
// R15 - Transmit burst read holds bus to end
// R16 - Transmit address is page and byte count
// R17 - Transmit page advances, wraps to free start
// R18 - Byte counter restarts on each new page
// ****************************************
//
// Local design decision: the plain strobed port.
`timescale 1ns/100ps
`include "pmdma_regs.svh"
module pmdma_arb
   import pmdma_pkg::*;
#(
   parameter int FIFO_DEPTH = 64,
   parameter int CNT_W = 7
)
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic ce,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   output logic irq,
   input wire logic [CNT_W-1:0] rx_fifo_count,
   input wire logic [CNT_W-1:0] tx_fifo_count,
   input wire logic rx_req,
   input wire logic tx_req,
   input wire logic host_req,
   input wire logic ring_start_free,
   output logic rx_pop,
   output logic tx_push,
   output logic host_gnt,
   output logic [19:0] packet_mem_addr,
   output logic mem_wr,
   output logic mem_rd
);
   // ****************************************
   // Registers
   // ****************************************
   logic [7:0] tuning_q;
   logic [2:0] status_q;
   logic [2:0] mask_q;
   logic [11:0] ring_start_page_q;
   logic [11:0] ring_last_page_q;
   logic [7:0] ivl_q;
   logic [7:0] host_interval_timer_q;
   logic [7:0] rdata_q;
   logic [2:0] events;
   pmdma_owner_e owner_q;
   pmdma_owner_e last_q;
   logic [5:0] beats_q;
   pmdma_chan_if rxc();
   pmdma_chan_if txc();

   // Burst code to transfer count: 4, 8, 16 or 32 beats; code 0 is 4.
   // Six bits wide so that the 32-beat code does not wrap to zero.
   function automatic logic [5:0] burst_len(input logic [1:0] code);
      burst_len = 6'h04 << code;
   endfunction

   // Threshold code to FIFO level: quarter steps of the depth.
   function automatic logic [CNT_W-1:0] thr_lvl(input logic [1:0] code);
      logic [31:0] v;
      v = (FIFO_DEPTH * (code + 1)) / 4;
      thr_lvl = v[CNT_W-1:0];
   endfunction

   logic [1:0] rx_thr;
   logic [1:0] tx_thr;
   logic rx_crit;
   logic tx_crit;
   logic host_crit;
   assign rx_thr = tuning_q[`PMDMA_RTH_HI:`PMDMA_RTH_LO];
   assign tx_thr = tuning_q[`PMDMA_TTH_HI:`PMDMA_TTH_LO];
   assign rx_crit = rx_fifo_count > thr_lvl(rx_thr); // R1
   assign tx_crit = (tx_thr != `PMDMA_TTH_SAF)
      && (tx_fifo_count < thr_lvl(tx_thr)); // R2 R13
   assign host_crit = host_interval_timer_q == 8'h00; // R3

   // Register writes; the tuning reset code gives half-depth thresholds
   // and four-beat bursts.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         tuning_q <= `PMDMA_TUNING_RST; // R7 R13 R14
         mask_q <= 3'h0;
         ring_start_page_q <= 12'h000;
         ring_last_page_q <= 12'hFFF;
         ivl_q <= `PMDMA_IVL_RST;
      end else if (ce && reg_wr) begin
         if (reg_addr == `PMDMA_OFS_TUNING) begin
            tuning_q <= reg_wdata;
         end else if (reg_addr == `PMDMA_OFS_MASK) begin
            mask_q <= reg_wdata[2:0];
         end else if (reg_addr == `PMDMA_OFS_RING_START) begin
            ring_start_page_q <= {4'h0, reg_wdata};
         end else if (reg_addr == `PMDMA_OFS_RING_LAST) begin
            ring_last_page_q <= {4'h0, reg_wdata};
         end else if (reg_addr == `PMDMA_OFS_HOST_IVL) begin
            ivl_q <= reg_wdata;
         end
      end
   end

   // Sticky status; a new event wins over a write-one clear.
   assign events = {txc.page_done, rxc.page_done, rxc.wrap_fail};
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         status_q <= 3'h0;
      end else if (ce) begin
         if (reg_wr && reg_addr == `PMDMA_OFS_STATUS) begin
            status_q <= (status_q & ~reg_wdata[2:0]) | events;
         end else begin
            status_q <= status_q | events; // R12
         end
      end
   end
   assign irq = |(status_q & mask_q);

   // Read data stands one cycle after the strobe; unmapped reads zero.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rdata_q <= 8'h00;
      end else if (ce && reg_rd) begin
         if (reg_addr == `PMDMA_OFS_TUNING) begin
            rdata_q <= tuning_q;
         end else if (reg_addr == `PMDMA_OFS_STATUS) begin
            rdata_q <= {5'h00, status_q};
         end else if (reg_addr == `PMDMA_OFS_MASK) begin
            rdata_q <= {5'h00, mask_q};
         end else if (reg_addr == `PMDMA_OFS_RING_START) begin
            rdata_q <= ring_start_page_q[7:0];
         end else if (reg_addr == `PMDMA_OFS_RING_LAST) begin
            rdata_q <= ring_last_page_q[7:0];
         end else if (reg_addr == `PMDMA_OFS_HOST_IVL) begin
            rdata_q <= ivl_q;
         end else if (reg_addr == `PMDMA_OFS_RX_PAGE) begin
            rdata_q <= rxc.page[7:0];
         end else if (reg_addr == `PMDMA_OFS_TX_PAGE) begin
            rdata_q <= txc.page[7:0];
         end else begin
            rdata_q <= 8'h00;
         end
      end else if (ce) begin
         rdata_q <= 8'h00;
      end
   end
   assign reg_rdata = rdata_q;

   // Host interval timer counts down while host waits; reloads on grant.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         host_interval_timer_q <= `PMDMA_IVL_RST;
      end else if (ce) begin
         if (owner_q == PMDMA_HOST || !host_req) begin
            host_interval_timer_q <= ivl_q;
         end else if (host_interval_timer_q != 8'h00) begin
            host_interval_timer_q <= host_interval_timer_q - 8'h01; // R3
         end
      end
   end

   // ****************************************
   // Arbitration
   // ****************************************
   pmdma_owner_e pick;
   always_comb begin
      pick = PMDMA_IDLE;
      if (host_crit && host_req) begin
         pick = PMDMA_HOST; // R4
      end else if (rx_crit && rx_req) begin
         pick = PMDMA_RX; // R5 R4
      end else if (tx_crit && tx_req) begin
         pick = PMDMA_TX; // R6 R13
      end else if (rx_req && tx_req) begin
         // Equal standing: alternate so neither starves.
         pick = (last_q == PMDMA_RX) ? PMDMA_TX : PMDMA_RX; // R4 R6
      end else if (rx_req) begin
         pick = PMDMA_RX; // R8
      end else if (tx_req) begin
         pick = PMDMA_TX; // R8
      end else if (host_req) begin
         pick = PMDMA_HOST; // R8
      end
   end

   // A receive or transmit owner holds the bus until its burst count is spent; a host owner re-arbitrates every cycle.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         owner_q <= PMDMA_IDLE;
         last_q <= PMDMA_TX;
         beats_q <= 6'h00;
      end else if (ce) begin
         if (owner_q == PMDMA_IDLE || owner_q == PMDMA_HOST ||
             beats_q == 6'h01) begin
            owner_q <= pick;
            if (pick != PMDMA_IDLE) begin
               last_q <= pick;
            end
            if (pick == PMDMA_RX) begin
               beats_q <= burst_len(tuning_q[`PMDMA_RBL_HI:`PMDMA_RBL_LO]);
            end else if (pick == PMDMA_TX) begin
               beats_q <= burst_len(tuning_q[`PMDMA_TBL_HI:`PMDMA_TBL_LO]);
            end else begin
               beats_q <= 6'h00;
            end
         end else begin
            beats_q <= beats_q - 6'h01; // R9 R15
         end
      end
   end

   // ****************************************
   // Channels and memory strobes
   // ****************************************
   assign rxc.step = ce && owner_q == PMDMA_RX;
   assign txc.step = ce && owner_q == PMDMA_TX;
   assign rxc.start_page = ring_start_page_q;
   assign txc.start_page = ring_start_page_q;
   assign rxc.last_page = ring_last_page_q;
   assign txc.last_page = ring_last_page_q;
   assign rxc.start_free = ring_start_free;
   assign txc.start_free = ring_start_free;

   pmdma_chan u_rx (
      .clk(clk),
      .nrst(nrst),
      .ce(ce),
      .c(rxc)
   );
   pmdma_chan u_tx (
      .clk(clk),
      .nrst(nrst),
      .ce(ce),
      .c(txc)
   );

   assign mem_wr = owner_q == PMDMA_RX; // R9
   assign mem_rd = owner_q == PMDMA_TX; // R15
   assign rx_pop = mem_wr;
   assign tx_push = mem_rd;
   assign host_gnt = owner_q == PMDMA_HOST;
   assign packet_mem_addr = mem_rd ? txc.addr : rxc.addr; // R10 R16

   // ****************************************
   // Assertions
   // ****************************************
   a_rx_burst_hold: assert property (@(posedge clk) disable iff (!nrst)
      ce && owner_q == PMDMA_IDLE && pick == PMDMA_RX &&
      tuning_q[7:6] == 2'b00 ##1 ce[*3] |-> owner_q == PMDMA_RX) // R9
      else $error("receive burst lost the bus early");
   a_tx_burst_hold: assert property (@(posedge clk) disable iff (!nrst)
      owner_q == PMDMA_TX && beats_q > 6'h01 && ce |=>
      owner_q == PMDMA_TX) // R15
      else $error("transmit burst lost the bus early");
   a_rx_over_tx: assert property (@(posedge clk) disable iff (!nrst)
      rx_crit && rx_req && !(host_crit && host_req) |->
      pick == PMDMA_RX) // R5
      else $error("critical receive not chosen");
   a_host_first: assert property (@(posedge clk) disable iff (!nrst)
      host_crit && host_req |-> pick == PMDMA_HOST) // R4
      else $error("critical host not chosen");
   a_tx_saf_calm: assert property (@(posedge clk) disable iff (!nrst)
      tuning_q[1:0] == 2'b11 |-> !tx_crit) // R2
      else $error("transmit critical in store-forward");
   a_tx_over_rx: assert property (@(posedge clk) disable iff (!nrst)
      tx_crit && tx_req && !rx_crit && !(host_crit && host_req) |->
      pick == PMDMA_TX) // R6
      else $error("critical transmit not chosen");
   a_rx_thresh: assert property (@(posedge clk) disable iff (!nrst)
      rx_fifo_count <= thr_lvl(tuning_q[3:2]) |-> !rx_crit) // R1
      else $error("receive critical below threshold");
   a_rx_addr_map: assert property (@(posedge clk) disable iff (!nrst)
      mem_wr |-> packet_mem_addr[19:8] == rxc.page) // R10
      else $error("receive address page mismatch");
   a_full_flag: assert property (@(posedge clk) disable iff (!nrst)
      ce && rxc.wrap_fail |=> status_q[`PMDMA_ST_RXFULL]) // R12
      else $error("buffer full not flagged");
   a_host_timer: assert property (@(posedge clk) disable iff (!nrst)
      ce && host_req && owner_q != PMDMA_HOST &&
      host_interval_timer_q == 8'h01 |=> host_crit) // R3
      else $error("host timer did not expire");
   c_rx_burst: cover property (@(posedge clk) owner_q == PMDMA_RX);
   c_tx_burst: cover property (@(posedge clk) owner_q == PMDMA_TX);
   c_host_gnt: cover property (@(posedge clk) host_gnt && host_crit);
   c_wrap_fail: cover property (@(posedge clk) rxc.wrap_fail);
endmodule

// *** dv/pmdma_sram_model.sv ***
// Packet memory model that follows the beats on the shared memory bus.
`timescale 1ns/100ps
module pmdma_sram_model (
   input wire logic clk,
   input wire logic nrst,
   input wire logic mem_wr,
   input wire logic mem_rd,
   input wire logic [19:0] packet_mem_addr,
   output logic step_err
);
   logic busy_q;
   logic kind_q;
   logic [19:0] last_q;
   // Each beat moves one byte, so the byte field steps by one; the page may
   // change only where the byte field wraps, to the next or start page, or
   // stay put when a full ring refuses the wrap.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         busy_q <= 1'b0;
         kind_q <= 1'b0;
         last_q <= 20'h00000;
         step_err <= 1'b0;
      end else begin
         busy_q <= mem_wr | mem_rd;
         kind_q <= mem_wr;
         last_q <= packet_mem_addr;
         if (busy_q && (mem_wr | mem_rd) && kind_q == mem_wr &&
             (packet_mem_addr[7:0] != last_q[7:0] + 8'h01 ||
              (last_q[7:0] != 8'hFF &&
               packet_mem_addr[19:8] != last_q[19:8]))) begin
            step_err <= 1'b1;
         end
      end
   end
endmodule

// *** dv/packet_memory_local_dma_arbiter_tb.sv ***
// Self-checking testbench of the packet memory DMA arbiter.
`timescale 1ns/100ps
`include "pmdma_regs.svh"
module packet_memory_local_dma_arbiter_tb;
   logic clk, nrst, ce, reg_wr, reg_rd, irq, rx_req, tx_req, host_req;
   logic ring_start_free, rx_pop, tx_push, host_gnt, mem_wr, mem_rd;
   logic step_err;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
   logic [6:0] rx_fifo_count, tx_fifo_count;
   logic [19:0] packet_mem_addr;
   logic [11:0] p0;
   int n_fail = 0;
   int total_checks = 0;
   int rb = 0;
   pmdma_arb DUT (.clk(clk), .nrst(nrst), .ce(ce), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .irq(irq), .rx_fifo_count(rx_fifo_count),
      .tx_fifo_count(tx_fifo_count), .rx_req(rx_req), .tx_req(tx_req),
      .host_req(host_req), .ring_start_free(ring_start_free),
      .rx_pop(rx_pop), .tx_push(tx_push), .host_gnt(host_gnt),
      .packet_mem_addr(packet_mem_addr), .mem_wr(mem_wr), .mem_rd(mem_rd));
   pmdma_sram_model mem (.clk(clk), .nrst(nrst), .mem_wr(mem_wr),
      .mem_rd(mem_rd), .packet_mem_addr(packet_mem_addr),
      .step_err(step_err));
   // ****************************************
   // Bus tasks
   // ****************************************
   task automatic chk(input logic [19:0] seen, input logic [19:0] exp,
                      input string msg);
      total_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, msg,
                  seen, exp);
      end
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   // Read data stand only in the cycle after the strobe, so sample there.
   task automatic rd_reg(input logic [7:0] a, output logic [7:0] v);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      v = reg_rdata;
   endtask
   // Requests are levels; drop them at the first beat so bursts never merge.
   task automatic burst(input bit rx, output int n, output logic [19:0] a0);
      int w;
      n = 0;
      w = 0;
      @(posedge clk);
      if (rx) rx_req <= 1'b1;
      else tx_req <= 1'b1;
      do begin
         @(posedge clk);
         #1;
         w++;
      end while ((rx ? mem_wr : mem_rd) !== 1'b1 && w < 60);
      a0 = packet_mem_addr;
      while ((rx ? mem_wr : mem_rd) === 1'b1 && n < 80) begin
         n++;
         @(posedge clk);
         rx_req <= 1'b0;
         tx_req <= 1'b0;
         #1;
      end
   endtask
   task automatic rx_go(input int exp_n);
      int n;
      logic [19:0] a;
      burst(1'b1, n, a);
      chk(20'(n), 20'(exp_n), "rx beats");
      chk(a, {p0 + 12'(rb / 256), 8'(rb % 256)}, "rx address");
      rb += n;
   endtask
   // Both channels ask at once; the first owner shows the ranking.
   task automatic race(input logic [6:0] rc, input logic [6:0] tc,
                       input logic [1:0] exp);
      int w;
      @(posedge clk);
      rx_fifo_count <= rc;
      tx_fifo_count <= tc;
      @(posedge clk);
      rx_req <= 1'b1;
      tx_req <= 1'b1;
      w = 0;
      do begin
         @(posedge clk);
         #1;
         w++;
      end while (mem_wr !== 1'b1 && mem_rd !== 1'b1 && w < 60);
      chk({18'h0, mem_rd, mem_wr}, {18'h0, exp}, "first owner");
      chk({18'h0, tx_push, rx_pop}, {18'h0, exp}, "fifo strobes");
      @(posedge clk);
      rx_req <= 1'b0;
      tx_req <= 1'b0;
      repeat (20) @(posedge clk);
      if (exp == 2'b01) rb += 4;
   endtask
   task automatic test_done;
      $display("checks %0d failures %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   // ****************************************
   // Clock, watchdog and tests
   // ****************************************
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // The whole run needs well under 10000 cycles.
   initial begin
      #100000;
      n_fail++;
      $display("CHECK FAILED at %0t: watchdog expired", $time);
      test_done();
   end
   initial begin
      int n;
      logic [19:0] a;
      {nrst, reg_wr, reg_rd, rx_req, tx_req, host_req} = 6'h00;
      {reg_addr, reg_wdata} = 16'h0000;
      ce = 1'b1;
      ring_start_free = 1'b1;
      rx_fifo_count = 7'h00;
      tx_fifo_count = 7'h00;
      repeat (5) @(posedge clk);
      nrst <= 1'b1;
      rd_reg(`PMDMA_OFS_TUNING, d);
      chk(20'(d), 20'(`PMDMA_TUNING_RST), "tuning reset");
      rd_reg(`PMDMA_OFS_HOST_IVL, d);
      chk(20'(d), 20'(`PMDMA_IVL_RST), "interval reset");
      wr_reg(8'h40, 8'hA5);
      rd_reg(8'h40, d);
      chk(20'(d), 20'h00000, "unmapped read");
      rd_reg(`PMDMA_OFS_RX_PAGE, d);
      p0 = 12'(d);
      $display("test registers done");
      race(7'h28, 7'h0A, 2'b01);
      race(7'h00, 7'h0A, 2'b10);
      @(posedge clk);
      host_req <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         #1;
         n++;
      end while (host_gnt !== 1'b1 && n < 40);
      chk(20'(host_gnt), 20'h00001, "host grant");
      @(posedge clk);
      host_req <= 1'b0;
      // A critical receive alone would starve the host; the timer must win.
      wr_reg(`PMDMA_OFS_HOST_IVL, 8'h02);
      rx_fifo_count <= 7'h28;
      @(posedge clk);
      {rx_req, tx_req, host_req} <= 3'b111;
      n = 0;
      do begin
         @(posedge clk);
         #1;
         n++;
      end while (host_gnt !== 1'b1 && n < 40);
      chk(20'(host_gnt), 20'h00001, "critical host grant");
      @(posedge clk);
      {rx_req, tx_req, host_req} <= 3'b000;
      rb += 4;
      $display("test priority done");
      for (int c = 0; c < 4; c++) begin
         wr_reg(`PMDMA_OFS_TUNING, {2'(c), 2'(c), 4'h5});
         rx_go(4 << c);
         burst(1'b0, n, a);
         chk(20'(n), 20'(4 << c), "tx beats");
      end
      $display("test burst lengths done");
      while (rb < 256) rx_go(32);
      rd_reg(`PMDMA_OFS_STATUS, d);
      chk(20'(d[1]), 20'h00001, "page done flag");
      chk(20'(irq), 20'h00000, "masked irq");
      wr_reg(`PMDMA_OFS_MASK, 8'h02);
      #1;
      chk(20'(irq), 20'h00001, "irq raised");
      wr_reg(`PMDMA_OFS_STATUS, 8'h02);
      #1;
      chk(20'(irq), 20'h00000, "irq cleared");
      rd_reg(`PMDMA_OFS_RX_PAGE, d);
      chk(20'(d), 20'(8'(p0 + 12'h001)), "page advanced");
      rx_go(32);
      $display("test page advance done");
      wr_reg(`PMDMA_OFS_RING_LAST, 8'(p0 + 12'h001));
      ring_start_free <= 1'b0;
      while (rb < 512) rx_go(32);
      rd_reg(`PMDMA_OFS_STATUS, d);
      chk(20'(d[0]), 20'h00001, "buffer full flag");
      // Once the start page frees up, the next wrap lands on it (page zero).
      @(posedge clk);
      ring_start_free <= 1'b1;
      repeat (8) burst(1'b1, n, a);
      rd_reg(`PMDMA_OFS_RX_PAGE, d);
      chk(20'(d), 20'h00000, "ring wrapped to start");
      chk(20'(step_err), 20'h00000, "beat address steps");
      $display("test ring wrap done");
      test_done();
   end
endmodule
